// ==== hdl/cmpe_sync2.v ====
// two-stage synchroniser for the raw comparator level
// assumes clock is the system clock; input is asynchronous
`timescale 1ns/100ps
module cmpe_sync2
(
  input  wire clock,
  input  wire nrst,
  input  wire din,
  output wire dout
);
  reg meta_ff;
  reg sync_ff;

  // first stage feeds only the second stage
  always @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      meta_ff <= 1'b0;
      sync_ff <= 1'b0;
    end
    else
    begin
      meta_ff <= din;
      sync_ff <= meta_ff;
    end
  end

  assign dout = sync_ff;
endmodule // cmpe_sync2

// ==== hdl/cmpe_top.v ====
// comparator event control: input select, sync, event detect, flag, irq
// assumes analog core supplies raw result and vector acknowledge is one cycle
//
// The address-and-strobe port and the register offsets were left to the implementer.
`timescale 1ns/100ps
`include "cmpe_defs.vh"

// Summary of operation
// - raw result high when positive exceeds negative
// - synchronise result, lag one to two
// - mode: toggle, falling, rising; 01 reserved
// - selected event sets event flag bit 4
// - flag clears on vector or written one
// - request irq if flag, enable, global
// - power-off bit cuts comparator, writable anytime
// - bandgap bit selects positive reference
// - capture route feeds timer capture front
// - mux drives negative if enabled, converter off
// - channel bits pick converter inputs 0-15
module cmpe_top
(
  input  wire       clock,
  input  wire       nrst,
  input  wire [2:0] reg_addr,
  input  wire [7:0] reg_wdata,
  input  wire       reg_wr,
  input  wire       reg_rd,
  output reg  [7:0] reg_rdata,
  input  wire       cmp_raw,
  input  wire       vector_ack,
  input  wire       global_irq_en,
  input  wire [2:0] channel_select_low,
  output reg        comparator_power_off,
  output reg        bandgap_positive_select,
  output reg        negative_mux_enable_eff,
  output reg  [3:0] negative_channel,
  output reg        capture_out,
  output reg        comparator_irq,
  output reg        irq_out
);
  reg  [7:0] ctrl_ff;
  reg  [7:0] convb_ff;
  reg  [7:0] conva_ff;
  reg        evt_flag_ff;
  reg        prev_ff;
  reg  [1:0] irq_stat_ff;
  reg  [1:0] irq_en_ff;
  reg  [7:0] nxt_rdata;
  reg        evt_hit;
  wire       sync_out;
  wire       wr_ctrl;
  wire       flag_clr;
  wire       cap_edge;

  // per-register write decodes and sticky-bit clears
  wire       wr_convb;
  wire       wr_conva;
  wire       wr_irq_en;
  wire       wr_irq_clr;
  wire       stat_evt_clr;
  wire       stat_cap_clr;

  // next values of the state registers
  reg  [7:0] nxt_ctrl;
  reg  [7:0] nxt_convb;
  reg  [7:0] nxt_conva;
  reg        nxt_evt_flag;
  reg  [1:0] nxt_irq_stat;
  reg  [1:0] nxt_irq_en;

  // next values of the registered outputs
  reg  [7:0] nxt_rd_out;
  reg        nxt_power_off;
  reg        nxt_bandgap;
  reg        nxt_mux_eff;
  reg  [3:0] nxt_channel;
  reg        nxt_capture;
  reg        nxt_cmp_irq;
  reg        nxt_irq_out;

  // event path latency, counted in clock edges from a raw change:
  //   two edges through the synchroniser, one to set the flag,
  //   one more before the interrupt request pin follows it
  // a raw pulse shorter than a clock may be missed;
  // that is the price of a plain two-flop synchroniser

  // result from analog core: high when positive above negative
  // raw result input
  cmpe_sync2 u_sync
  (
    .clock (clock),
    .nrst  (nrst),
    .din   (cmp_raw),
    .dout  (sync_out)
  );

  assign wr_ctrl  = reg_wr && (reg_addr == `CMPE_OFS_CTRL);
  // clear by vector or written one
  assign flag_clr = vector_ack || (wr_ctrl && reg_wdata[`CMPE_B_EVT_FLAG]);
  assign cap_edge = ctrl_ff[`CMPE_B_CAP_ROUTE] && (sync_out != prev_ff);

  // write decodes for the remaining registers
  // unmapped indices match none of these, so their writes are dropped
  assign wr_convb   = reg_wr && (reg_addr == `CMPE_OFS_CONVB);
  assign wr_conva   = reg_wr && (reg_addr == `CMPE_OFS_CONVA);
  assign wr_irq_en  = reg_wr && (reg_addr == `CMPE_OFS_IRQ_EN);
  assign wr_irq_clr = reg_wr && (reg_addr == `CMPE_OFS_IRQ_CLR);

  // write-one clears of the sticky status bits
  assign stat_evt_clr = wr_irq_clr && reg_wdata[`CMPE_IRQ_B_EVENT];
  assign stat_cap_clr = wr_irq_clr && reg_wdata[`CMPE_IRQ_B_CAPTURE];

  // event decode per mode
  always @*
  begin
    evt_hit = 1'b0;
    case (ctrl_ff[`CMPE_B_MODE_HI:`CMPE_B_MODE_LO])
      `CMPE_MODE_TOGGLE: evt_hit = sync_out ^ prev_ff;
      `CMPE_MODE_FALL:   evt_hit = prev_ff & ~sync_out;
      `CMPE_MODE_RISE:   evt_hit = ~prev_ff & sync_out;
      default:           evt_hit = 1'b0; // reserved mode: no events
    endcase
    // powered-off comparator produces no events
    if (ctrl_ff[`CMPE_B_POWER_OFF])
      evt_hit = 1'b0;
  end

  // control register; status and flag positions are not storage, kept zero
  // a one written to the flag position only clears it, see flag_clr
  // power-off bit writable at any time
  always @*
  begin
    nxt_ctrl = ctrl_ff;
    if (wr_ctrl)
      nxt_ctrl = {reg_wdata[7:6], 2'h0, reg_wdata[3:0]};
  end

  // converter control b: mux enable, channel high and trigger bits kept
  always @*
  begin
    nxt_convb = convb_ff;
    if (wr_convb)
      nxt_convb = {1'b0, reg_wdata[6], 2'h0, reg_wdata[3:0]};
  end

  // local mirror of converter control a, only its enable bit is used
  // software keeps this mirror in step with the converter itself
  always @*
  begin
    nxt_conva = conva_ff;
    if (wr_conva)
      nxt_conva = reg_wdata;
  end

  // interrupt enable bits for the level output
  // bits above the two status positions are ignored
  always @*
  begin
    nxt_irq_en = irq_en_ff;
    if (wr_irq_en)
      nxt_irq_en = reg_wdata[1:0];
  end

  // vector or written one clears it
  // set wins, so an event landing in the clear cycle is not lost
  // a mode change with the enable set may flag a stale edge;
  // software keeps the enable clear across such changes
  always @*
  begin
    nxt_evt_flag = evt_flag_ff;
    if (evt_hit)
      nxt_evt_flag = 1'b1;
    else if (flag_clr)
      nxt_evt_flag = 1'b0;
  end

  // sticky status: clear first, then a same-cycle set overrides it
  // status bit 1 follows the routed output, so it reports capture edges
  always @*
  begin
    nxt_irq_stat = irq_stat_ff;
    if (stat_evt_clr)
      nxt_irq_stat[`CMPE_IRQ_B_EVENT] = 1'b0;
    if (stat_cap_clr)
      nxt_irq_stat[`CMPE_IRQ_B_CAPTURE] = 1'b0;
    if (evt_hit)
      nxt_irq_stat[`CMPE_IRQ_B_EVENT] = 1'b1;
    if (cap_edge)
      nxt_irq_stat[`CMPE_IRQ_B_CAPTURE] = 1'b1;
  end

  // state registers; prev_ff holds the last sample for edge detection
  always @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      ctrl_ff     <= `CMPE_RST_CTRL;
      convb_ff    <= `CMPE_RST_CONVB;
      conva_ff    <= `CMPE_RST_CONVA;
      evt_flag_ff <= 1'b0;
      prev_ff     <= 1'b0;
      irq_stat_ff <= 2'h0;
      irq_en_ff   <= 2'h0;
    end
    else
    begin
      ctrl_ff     <= nxt_ctrl;
      convb_ff    <= nxt_convb;
      conva_ff    <= nxt_conva;
      evt_flag_ff <= nxt_evt_flag;
      prev_ff     <= sync_out;
      irq_stat_ff <= nxt_irq_stat;
      irq_en_ff   <= nxt_irq_en;
    end
  end

  // read mux, data valid the cycle after the strobe
  always @*
  begin
    nxt_rdata = 8'h00;
    case (reg_addr)
      `CMPE_OFS_CTRL:     nxt_rdata = {ctrl_ff[7:6], sync_out, evt_flag_ff, ctrl_ff[3:0]};
      `CMPE_OFS_CONVB:    nxt_rdata = convb_ff;
      `CMPE_OFS_IRQ_STAT: nxt_rdata = {6'h00, irq_stat_ff};
      `CMPE_OFS_IRQ_EN:   nxt_rdata = {6'h00, irq_en_ff};
      `CMPE_OFS_CONVA:    nxt_rdata = conva_ff;
      default:            nxt_rdata = 8'h00; // unmapped and write-only read zero
    endcase
  end

  // read data only in the slot after the strobe, zero otherwise
  // idle zero keeps a shared read bus quiet
  always @*
  begin
    nxt_rd_out = 8'h00;
    if (reg_rd)
      nxt_rd_out = nxt_rdata;
  end

  // analog selects; registered so the core never sees decode glitches
  always @*
  begin
    nxt_power_off = ctrl_ff[`CMPE_B_POWER_OFF];
    nxt_bandgap = ctrl_ff[`CMPE_B_BANDGAP];
    nxt_mux_eff = convb_ff[`CMPE_B_NEG_MUX_EN] & ~conva_ff[`CMPE_B_CONV_EN];
    nxt_channel = {convb_ff[`CMPE_B_CHAN_HI], channel_select_low};
  end

  // route to capture front end, else held low
  // no filtering here: the timer's own noise canceller does that
  always @*
  begin
    nxt_capture = ctrl_ff[`CMPE_B_CAP_ROUTE] & sync_out;
  end

  // interrupt levels; a flag clear in flight masks comparator_irq at once, not irq_out
  always @*
  begin
    nxt_cmp_irq = evt_flag_ff & ctrl_ff[`CMPE_B_IRQ_EN] & global_irq_en & ~flag_clr;
    // level output: any enabled sticky status bit
    nxt_irq_out = |(irq_stat_ff & irq_en_ff);
  end

  // registered outputs: no combinational path from the register port
  // or the raw input reaches any pin
  always @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      reg_rdata               <= 8'h00;
      comparator_power_off    <= 1'b0;
      bandgap_positive_select <= 1'b0;
      negative_mux_enable_eff <= 1'b0;
      negative_channel        <= 4'h0;
      capture_out             <= 1'b0;
      comparator_irq          <= 1'b0;
      irq_out                 <= 1'b0;
    end
    else
    begin
      reg_rdata               <= nxt_rd_out;
      comparator_power_off    <= nxt_power_off;
      bandgap_positive_select <= nxt_bandgap;
      negative_mux_enable_eff <= nxt_mux_eff;
      negative_channel        <= nxt_channel;
      capture_out             <= nxt_capture;
      comparator_irq          <= nxt_cmp_irq;
      irq_out                 <= nxt_irq_out;
    end
  end
endmodule // cmpe_top

// ==== pkg/cmpe_defs.vh ====
// register offsets, field positions, reset values for the comparator event block
// assumes inclusion by bare name from design files under hdl/
`ifndef CMPE_DEFS_VH
`define CMPE_DEFS_VH

// register indices on the plain port (chosen)
`define CMPE_ADDR_W        3
`define CMPE_OFS_CTRL      3'h0
`define CMPE_OFS_CONVB     3'h1
`define CMPE_OFS_IRQ_STAT  3'h2
`define CMPE_OFS_IRQ_EN    3'h3
`define CMPE_OFS_IRQ_CLR   3'h4
`define CMPE_OFS_CONVA     3'h5

// comparator control/status fields
`define CMPE_B_POWER_OFF   7
`define CMPE_B_BANDGAP     6
`define CMPE_B_OUT_STATUS  5
`define CMPE_B_EVT_FLAG    4
`define CMPE_B_IRQ_EN      3
`define CMPE_B_CAP_ROUTE   2
`define CMPE_B_MODE_HI     1
`define CMPE_B_MODE_LO     0

// converter control b fields
`define CMPE_B_NEG_MUX_EN  6
`define CMPE_B_CHAN_HI     3

// converter control a (local mirror): converter enable
`define CMPE_B_CONV_EN     7

// event modes
`define CMPE_MODE_TOGGLE   2'h0
`define CMPE_MODE_RSVD     2'h1
`define CMPE_MODE_FALL     2'h2
`define CMPE_MODE_RISE     2'h3

// reset values
`define CMPE_RST_CTRL      8'h00
`define CMPE_RST_CONVB     8'h00
`define CMPE_RST_CONVA     8'h00

// status bit positions in irq status/enable/clear
`define CMPE_IRQ_B_EVENT   0
`define CMPE_IRQ_B_CAPTURE 1

`endif

// ==== tb/cmpe_analog_model.sv ====
// behavioural comparator core, voltages in millivolts
// assumes selects come straight from the block outputs
`timescale 1ns/100ps
module cmpe_analog_model
(
  input wire logic       power_off,
  input wire logic       bg_sel,
  input wire logic       mux_en,
  input wire logic [3:0] chan,
  input wire logic signed [31:0] pos_mv,
  input wire logic signed [31:0] neg_mv,
  input wire logic signed [31:0] bg_mv,
  output logic           raw
);
  // compare selected inputs
  // mux channel n sits at n*100 mV; unpowered core reads low
  // converter power-reduce taken as zero, so the mux always answers
  always_comb raw = !power_off && ((bg_sel ? bg_mv : pos_mv) > (mux_en ? chan * 100 : neg_mv));
endmodule // cmpe_analog_model

// ==== tb/cmpe_monitor.sv ====
// port checker for the comparator event block
// assumes bind onto cmpe_top, one clock domain
`timescale 1ns/100ps
module cmpe_monitor
(
  input logic       clock,
  input logic       nrst,
  input logic [2:0] reg_addr,
  input logic [7:0] reg_wdata,
  input logic       reg_wr,
  input logic       reg_rd,
  input logic [7:0] reg_rdata,
  input logic       vector_ack,
  input logic       global_irq_en,
  input logic [2:0] channel_select_low,
  input logic       comparator_power_off,
  input logic       bandgap_positive_select,
  input logic [3:0] negative_channel,
  input logic       comparator_irq
);
  default clocking @(posedge clock); endclocking
  default disable iff (!nrst);
  // nothing that could drop the flag or enable
  sequence s_no_clr;
    !vector_ack && !(reg_wr && reg_addr == 3'h0);
  endsequence
  chk_irq_gated: assert property (!global_irq_en |=> !comparator_irq)
    else $error("irq without global enable");
  chk_vec_clear: assert property (vector_ack |=> !comparator_irq)
    else $error("irq stays after vector");
  chk_w1c_clear: assert property (reg_wr && reg_addr == 3'h0 && reg_wdata[4]
    |=> !comparator_irq)
    else $error("irq stays after flag write");
  chk_irq_sticky: assert property (comparator_irq && global_irq_en
    && !$past(reg_wr && reg_addr == 3'h0) ##0 s_no_clr |=> comparator_irq)
    else $error("irq dropped unasked");
  chk_pwr_write: assert property (reg_wr && reg_addr == 3'h0
    |-> ##2 comparator_power_off == $past(reg_wdata[7], 2))
    else $error("power bit not taken");
  chk_bg_write: assert property (reg_wr && reg_addr == 3'h0
    |-> ##2 bandgap_positive_select == $past(reg_wdata[6], 2))
    else $error("bandgap bit not taken");
  chk_chan_low: assert property ($past(nrst) && $stable(channel_select_low)
    |=> negative_channel[2:0] == $past(channel_select_low))
    else $error("channel low bits wrong");
  chk_rd_idle: assert property (!reg_rd |=> reg_rdata == 8'h00)
    else $error("read data outside read slot");
  chk_rd_unmapped: assert property (reg_rd && (reg_addr > 3'h5 || reg_addr == 3'h4) |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
endmodule // cmpe_monitor

bind cmpe_top cmpe_monitor u_mon (.*);

// ==== tb/tb_cmpe_top.sv ====
// self-checking bench for the comparator event block
// assumes the behavioural core model drives the raw result
`timescale 1ns/100ps
module tb_cmpe_top;
  logic clock = 0, nrst = 0, reg_wr = 0, reg_rd = 0, vector_ack = 0, global_irq_en = 0;
  logic [2:0] reg_addr = 3'h0, channel_select_low = 3'h0;
  logic [7:0] reg_wdata = 8'h00;
  wire [7:0] reg_rdata;
  wire [3:0] negative_channel;
  wire cmp_raw, comparator_power_off, bandgap_positive_select, negative_mux_enable_eff;
  wire capture_out, comparator_irq, irq_out;
  int pos = 0, neg = 500, bgv = 1200, fails = 0, tests_run = 0;
  // clock
  always #5 clock = ~clock;
  cmpe_top uut (.*);
  cmpe_analog_model u_ana (.power_off(comparator_power_off), .bg_sel(bandgap_positive_select),
    .mux_en(negative_mux_enable_eff), .chan(negative_channel), .pos_mv(pos), .neg_mv(neg),
    .bg_mv(bgv), .raw(cmp_raw));
  task ck(string n, logic [7:0] e, logic [7:0] s);
    tests_run++;
    if (s !== e)
    begin
      fails++;
      $display("MISMATCH %s exp %h got %h", n, e, s);
    end
  endtask
  task wr(logic [2:0] a, logic [7:0] d);
    @(posedge clock);
    {reg_wr, reg_addr, reg_wdata} <= {1'b1, a, d};
    @(posedge clock);
    reg_wr <= 1'b0;
    #1;
  endtask
  task rd(logic [2:0] a, logic [7:0] e);
    @(posedge clock);
    {reg_rd, reg_addr} <= {1'b1, a};
    @(posedge clock);
    reg_rd <= 1'b0;
    #1 ck("rdata", e, reg_rdata);
  endtask
  // raw moves, then wait out sync and flag latency
  task ev(int p);
    pos <= p;
    repeat (4) @(posedge clock);
    #1;
  endtask
  task tally_and_finish;
    $display("checks %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // cut a hang short
  initial
  begin
    #100000 fails++;
    tally_and_finish;
  end
  // main sequence
  initial
  begin
    repeat (10) @(posedge clock);
    nrst <= 1'b1;
    rd(0, 8'h00); rd(1, 8'h00); rd(5, 8'h00); rd(6, 8'h00);
    $display("test reset done");
    for (int m = 0; m < 4; m++)
    begin
      wr(0, {6'h04, m[1:0]}); // enable stays clear across mode changes
      ev(1000); rd(0, {3'h1, m == 0 || m == 3, 2'h0, m[1:0]});
      wr(0, {6'h04, m[1:0]});
      ev(0); rd(0, {3'h0, m == 0 || m == 2, 2'h0, m[1:0]});
    end
    $display("test modes done");
    wr(3, 8'h01); wr(0, 8'h18); ev(1000);
    ck("irq_no_gie", 8'h00, comparator_irq);
    @(posedge clock);
    global_irq_en <= 1'b1;
    @(posedge clock);
    #1 ck("irq", 8'h01, comparator_irq);
    ck("irq_out", 8'h01, irq_out); rd(2, 8'h01);
    @(posedge clock);
    vector_ack <= 1'b1;
    @(posedge clock);
    vector_ack <= 1'b0;
    #1 ck("irq_vec", 8'h00, comparator_irq);
    rd(0, 8'h28); wr(3, 8'h00); @(posedge clock);
    #1 ck("irq_masked", 8'h00, irq_out);
    wr(4, 8'h01); rd(2, 8'h00); rd(4, 8'h00);
    $display("test irq done");
    ev(0); wr(0, 8'h10); wr(0, 8'h55); ev(0);
    ck("bandgap", 8'h01, bandgap_positive_select);
    // timer capture irq enable belongs to the timer, not modelled here
    ck("capture", 8'h01, capture_out); rd(0, 8'h65);
    wr(0, 8'h81); ev(0); rd(0, 8'h81);
    ck("power_off", 8'h01, comparator_power_off);
    $display("test power done");
    channel_select_low <= 3'h5;
    wr(1, 8'h48); rd(1, 8'h48);
    ck("mux_eff", 8'h01, negative_mux_enable_eff);
    ck("chan", 8'h0d, negative_channel);
    wr(5, 8'h80); @(posedge clock);
    #1 ck("mux_conv_on", 8'h00, negative_mux_enable_eff);
    $display("test mux done");
    tally_and_finish;
  end
endmodule // tb_cmpe_top
